//--- rtl/pmos_defs.vh
// register offsets, control fields and timing constants for the period meter / one-shot channel
`ifndef PMOS_DEFS_VH
`define PMOS_DEFS_VH
// printed offsets are not all multiples of four, so they are indices; byte address = 4 * index
`define PMOS_IDX_BOARD 4'h0
`define PMOS_IDX_IRQ 4'h2
`define PMOS_IDX_TRIG 4'h4
`define PMOS_IDX_CTRL 4'h8
`define PMOS_IDX_CONST_A 4'h9
`define PMOS_IDX_CONST_B 4'ha
`define PMOS_IDX_COUNT 4'hb
// control word fields
`define PMOS_F_MODE_HI 2
`define PMOS_F_MODE_LO 0
`define PMOS_F_OUT_POL 3
`define PMOS_F_IN_HI 5
`define PMOS_F_IN_LO 4
`define PMOS_F_CLK_HI 7
`define PMOS_F_CLK_LO 6
`define PMOS_F_TRG_HI 9
`define PMOS_F_TRG_LO 8
`define PMOS_F_SRC_HI 12
`define PMOS_F_SRC_LO 10
`define PMOS_F_DEBOUNCE 13
`define PMOS_F_UNUSED 14
`define PMOS_F_IRQ_EN 15
`define PMOS_MODE_PERIOD 3'h6
`define PMOS_MODE_ONESHOT 3'h7
`define PMOS_SRC_EXT 3'h5
`define PMOS_POL_LOW 2'h1
`define PMOS_POL_HIGH 2'h2
`define PMOS_CTRL_RESET 16'h0000
`define PMOS_CTRL_WMASK 16'hbfff
// timing: system clock 50 MHz
`define PMOS_CLK_MHZ 50
`define PMOS_DONE_PULSE_NS 1750
`define PMOS_DONE_PULSE_CYC ((`PMOS_DONE_PULSE_NS * `PMOS_CLK_MHZ) / 1000)
`define PMOS_DEBOUNCE_NS 2500
`define PMOS_DEBOUNCE_CYC ((`PMOS_DEBOUNCE_NS * `PMOS_CLK_MHZ + 999) / 1000)
`define PMOS_SLOW_TICK_MHZ 8
`define PMOS_FAST_TICK_MHZ 32
`endif

//--- rtl/pmos_channel.v
// period meter and one-shot counter channel with axi4-lite register slave
//
// Behaviour
// - mode 110 selects input period measurement
// - period mode measures only the first complete input cycle after trigger
// - bits 5:4 pick starting polarity: 01 low, 10 high, else input disabled
// - external clock counts only with bits 7:6 01/10 and source 101
// - source codes 000..100 pick internal tick, rate set by carrier speed
// - trigger from external input or soft trigger write; bits 9:8 set polarity
// - after trigger, timing begins at start of next active input portion
// - counter clears on trigger, counts selected ticks over measured cycle
// - completed measurement drives a 1.75 us output pulse
// - count saturates at ffff to flag overrange
// - interrupt enable raises interrupt when first full cycle ends, even count zero
// - pending interrupt held until write-one clear or enable bit cleared
// - bit 3 sets output active level; output idles high
// - bit 13 rejects input or trigger pulses of 2.5 us or less
// - control bit 14 reads back zero
// - mode 111 gives one output pulse per trigger, repeated on retrigger
// - constant a sets delay, constant b sets active pulse width
// - constants count down per tick; toggle on edge after zero, loading b only after a
// - enabled gate input runs or stops the one-shot counter by polarity
// - one-shot interrupt on both output transitions
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "pmos_defs.vh"
`default_nettype none
module pmos_channel #(
  parameter CW = 16
) (
  input wire clk,
  input wire rst_n,
  input wire measured_gate_input,
  input wire external_count_clock_input,
  input wire ext_trigger_input,
  output reg chan_out,
  output reg irq_out,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [CW-1:0] CNT_MAX = {CW{1'b1}};
  // counts are worked out as integers, then cut to the 8-bit counters on purpose
  localparam integer PULSE_CYC_I = `PMOS_DONE_PULSE_CYC;
  localparam integer DEB_CYC_I = `PMOS_DEBOUNCE_CYC;
  localparam [7:0] PULSE_CYC = PULSE_CYC_I[7:0];
  localparam [7:0] DEB_CYC = DEB_CYC_I[7:0];
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_HALF1 = 3'h2;
  localparam [2:0] ST_HALF2 = 3'h3;
  localparam [2:0] ST_DELAY = 3'h4;
  localparam [2:0] ST_PULSE = 3'h5;
  localparam [2:0] ST_ARM = 3'h6;

  // reset release through two flops
  reg rst_s1_reg, rst_s2_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_ok_n = rst_s2_reg;

  // field pins synchronised; first stage read only by second
  reg [2:0] pin_s1_reg, pin_s2_reg;
  always @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {ext_trigger_input, external_count_clock_input, measured_gate_input};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // registers
  reg [15:0] ctrl_reg;
  reg board_fast_reg;
  reg [CW-1:0] const_a_reg, const_b_reg, count_reg;
  reg irq_pend_reg;
  wire [2:0] mode = ctrl_reg[`PMOS_F_MODE_HI:`PMOS_F_MODE_LO];
  wire [1:0] in_pol = ctrl_reg[`PMOS_F_IN_HI:`PMOS_F_IN_LO];
  wire [1:0] clk_pol = ctrl_reg[`PMOS_F_CLK_HI:`PMOS_F_CLK_LO];
  wire [1:0] trg_pol = ctrl_reg[`PMOS_F_TRG_HI:`PMOS_F_TRG_LO];
  wire [2:0] src = ctrl_reg[`PMOS_F_SRC_HI:`PMOS_F_SRC_LO];
  wire deb_en = ctrl_reg[`PMOS_F_DEBOUNCE];
  wire irq_en = ctrl_reg[`PMOS_F_IRQ_EN];

  // debounce filter: a level must hold past 2.5 us before it is accepted
  reg [1:0] filt_reg;
  reg [7:0] deb_a_reg, deb_t_reg;
  always @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      filt_reg <= 2'h0;
      deb_a_reg <= 8'h00;
      deb_t_reg <= 8'h00;
    end else begin
      if (!deb_en || pin_s2_reg[0] == filt_reg[0]) begin
        deb_a_reg <= 8'h00;
        if (!deb_en)
          filt_reg[0] <= pin_s2_reg[0];
      end else if (deb_a_reg >= DEB_CYC) begin
        filt_reg[0] <= pin_s2_reg[0];
        deb_a_reg <= 8'h00;
      end else begin
        deb_a_reg <= deb_a_reg + 8'h01;
      end
      if (!deb_en || pin_s2_reg[2] == filt_reg[1]) begin
        deb_t_reg <= 8'h00;
        if (!deb_en)
          filt_reg[1] <= pin_s2_reg[2];
      end else if (deb_t_reg >= DEB_CYC) begin
        filt_reg[1] <= pin_s2_reg[2];
        deb_t_reg <= 8'h00;
      end else begin
        deb_t_reg <= deb_t_reg + 8'h01;
      end
    end
  end

  // input active level per polarity field; 00 and 11 disable
  wire in_enabled = (in_pol == `PMOS_POL_LOW) || (in_pol == `PMOS_POL_HIGH);
  wire in_active = in_enabled && (filt_reg[0] == (in_pol == `PMOS_POL_HIGH));

  // trigger edge detect on filtered level
  reg trg_act_d_reg;
  wire trg_act = (trg_pol == `PMOS_POL_LOW) ? !filt_reg[1] :
                 (trg_pol == `PMOS_POL_HIGH) ? filt_reg[1] : 1'b0;
  reg soft_trig_reg;

  // tick generator: internal divider or external clock rising edge
  reg [6:0] div_reg;
  reg ext_d_reg;
  reg [6:0] div_top;
  always @* begin
    div_top = 7'd0;
    case (src)
      3'h0: div_top = board_fast_reg ? 7'd24 : 7'd99;
      3'h1: div_top = board_fast_reg ? 7'd11 : 7'd49;
      3'h2: div_top = board_fast_reg ? 7'd5 : 7'd24;
      3'h3: div_top = board_fast_reg ? 7'd2 : 7'd11;
      3'h4: div_top = board_fast_reg ? 7'd1 : 7'd5;
      default: div_top = 7'd0;
    endcase
  end
  wire ext_ok = (src == `PMOS_SRC_EXT) && (clk_pol == `PMOS_POL_LOW || clk_pol == `PMOS_POL_HIGH);
  wire int_tick = (src < `PMOS_SRC_EXT) && (div_reg >= div_top);
  wire tick = int_tick || (ext_ok && pin_s2_reg[1] && !ext_d_reg);

  // main sequencer state
  reg [2:0] state_reg;
  reg [7:0] pulse_cnt_reg;
  reg out_act_reg;
  reg zero_seen_reg;
  wire trig = soft_trig_reg || (trg_act && !trg_act_d_reg);
  wire [CW-1:0] count_dec = count_reg - {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] count_inc = (count_reg == CNT_MAX) ? CNT_MAX : count_reg + {{(CW-1){1'b0}}, 1'b1};
  reg irq_event;
  reg done_event;

  // axi write path
  reg aw_hold_reg, w_hold_reg;
  reg [3:0] aw_idx_reg;
  reg [31:0] wd_reg;
  wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire wr_ctrl = do_write && aw_idx_reg == `PMOS_IDX_CTRL;
  wire wr_a = do_write && aw_idx_reg == `PMOS_IDX_CONST_A;
  wire wr_irq_clr = do_write && aw_idx_reg == `PMOS_IDX_IRQ && wd_reg[0];

  always @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_idx_reg <= 4'h0;
      wd_reg <= 32'h0;
      ctrl_reg <= `PMOS_CTRL_RESET;
      board_fast_reg <= 1'b0;
      const_a_reg <= {CW{1'b0}};
      const_b_reg <= {CW{1'b0}};
      soft_trig_reg <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
      end
      soft_trig_reg <= 1'b0;
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        // write strobes ignored on all lanes; registers are 16 bits wide
        if (aw_idx_reg == `PMOS_IDX_BOARD)
          board_fast_reg <= wd_reg[0];
        else if (aw_idx_reg == `PMOS_IDX_IRQ)
          ; // clear handled in irq logic
        else if (aw_idx_reg == `PMOS_IDX_TRIG)
          soft_trig_reg <= 1'b1;
        else if (aw_idx_reg == `PMOS_IDX_CTRL)
          ctrl_reg <= wd_reg[15:0] & `PMOS_CTRL_WMASK;
        else if (aw_idx_reg == `PMOS_IDX_CONST_A)
          const_a_reg <= wd_reg[CW-1:0];
        else if (aw_idx_reg == `PMOS_IDX_CONST_B)
          const_b_reg <= wd_reg[CW-1:0];
        else
          s_axi_bresp <= 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read path; write-only trigger reads zero
  always @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0;
        if (s_axi_araddr[5:2] == `PMOS_IDX_BOARD)
          s_axi_rdata <= {31'h0, board_fast_reg};
        else if (s_axi_araddr[5:2] == `PMOS_IDX_IRQ)
          s_axi_rdata <= {31'h0, irq_pend_reg};
        else if (s_axi_araddr[5:2] == `PMOS_IDX_TRIG)
          s_axi_rdata <= 32'h0;
        else if (s_axi_araddr[5:2] == `PMOS_IDX_CTRL)
          s_axi_rdata <= {16'h0, ctrl_reg};
        else if (s_axi_araddr[5:2] == `PMOS_IDX_CONST_A)
          s_axi_rdata <= {{(32-CW){1'b0}}, const_a_reg};
        else if (s_axi_araddr[5:2] == `PMOS_IDX_CONST_B)
          s_axi_rdata <= {{(32-CW){1'b0}}, const_b_reg};
        else if (s_axi_araddr[5:2] == `PMOS_IDX_COUNT)
          s_axi_rdata <= {{(32-CW){1'b0}}, count_reg};
        else
          s_axi_rresp <= 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sequencer: period measurement and one-shot generation
  always @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      state_reg <= ST_IDLE;
      count_reg <= {CW{1'b0}};
      div_reg <= 7'd0;
      ext_d_reg <= 1'b0;
      trg_act_d_reg <= 1'b0;
      pulse_cnt_reg <= 8'h00;
      out_act_reg <= 1'b0;
      zero_seen_reg <= 1'b0;
      irq_event <= 1'b0;
      done_event <= 1'b0;
    end else begin
      irq_event <= 1'b0;
      done_event <= 1'b0;
      ext_d_reg <= pin_s2_reg[1];
      trg_act_d_reg <= trg_act;
      div_reg <= int_tick ? 7'd0 : div_reg + 7'd1;
      if (pulse_cnt_reg != 8'h00)
        pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
      if (wr_a && mode == `PMOS_MODE_ONESHOT)
        count_reg <= wd_reg[CW-1:0];
      if (wr_ctrl) begin
        state_reg <= ST_IDLE;
        out_act_reg <= 1'b0;
      end else if (mode == `PMOS_MODE_PERIOD) begin
        case (state_reg)
          ST_IDLE, ST_DELAY, ST_PULSE: begin
            if (trig) begin
              count_reg <= {CW{1'b0}};
              state_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            // an active portion already under way is skipped; timing starts at its next start
            if (!in_active)
              state_reg <= ST_ARM;
          end
          default: begin
            // armed, waiting for the active level to begin
            if (state_reg == ST_ARM) begin
              if (in_active)
                state_reg <= ST_HALF1;
            end else if (state_reg == ST_HALF1) begin
              if (tick)
                count_reg <= count_inc;
              if (!in_active)
                state_reg <= ST_HALF2;
            end else begin
              if (tick)
                count_reg <= count_inc;
              if (in_active || !in_enabled) begin
                state_reg <= ST_IDLE;
                pulse_cnt_reg <= PULSE_CYC;
                done_event <= 1'b1;
                irq_event <= 1'b1;
              end
            end
          end
        endcase
      end else if (mode == `PMOS_MODE_ONESHOT) begin
        if (trig) begin
          count_reg <= const_a_reg;
          zero_seen_reg <= 1'b0;
          out_act_reg <= 1'b0;
          state_reg <= ST_DELAY;
        end else if ((state_reg == ST_DELAY || state_reg == ST_PULSE) && (!in_enabled || in_active)) begin
          if (zero_seen_reg) begin
            // edge after zero detection: toggle output; from delay also load constant b
            zero_seen_reg <= 1'b0;
            irq_event <= 1'b1;
            if (state_reg == ST_DELAY) begin
              out_act_reg <= 1'b1;
              count_reg <= const_b_reg;
              state_reg <= ST_PULSE;
            end else begin
              out_act_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end else if (tick) begin
            if (count_reg == {CW{1'b0}})
              zero_seen_reg <= 1'b1;
            else
              count_reg <= count_dec;
          end
        end
      end else begin
        state_reg <= ST_IDLE;
        out_act_reg <= 1'b0;
      end
    end
  end

  // interrupt pending: set beats a simultaneous clear
  always @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n)
      irq_pend_reg <= 1'b0;
    else if (irq_event && irq_en)
      irq_pend_reg <= 1'b1;
    else if (wr_irq_clr || !irq_en)
      irq_pend_reg <= 1'b0;
  end

  // output pin: idles high, driven to chosen level while active
  always @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      chan_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_pend_reg;
      if (out_act_reg || pulse_cnt_reg != 8'h00 || done_event)
        chan_out <= ctrl_reg[`PMOS_F_OUT_POL];
      else
        chan_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verif/pmos_channel_props.sv
// concurrent checks on the period meter / one-shot channel ports
`timescale 1ns/10ps
`default_nettype none
module pmos_channel_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chan_out,
  input wire logic irq_out,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] wr_idx_reg;
  logic [3:0] rd_idx_reg;
  logic [3:0] since_chg_reg;
  logic last_out_reg;
  function automatic logic unm(input logic [3:0] i);
    return !(i inside {4'h0, 4'h2, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb});
  endfunction
  // remember accepted addresses so responses can be judged against them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx_reg <= 4'h0;
      rd_idx_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wr_idx_reg <= s_axi_awaddr[5:2];
      if (s_axi_arvalid && s_axi_arready) rd_idx_reg <= s_axi_araddr[5:2];
    end
  end
  // cycles since the output last moved; saturates so long idle spans stay cheap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_chg_reg <= 4'hf;
      last_out_reg <= 1'b1;
    end else begin
      last_out_reg <= chan_out;
      since_chg_reg <= (chan_out != last_out_reg) ? 4'h0 : (since_chg_reg == 4'hf) ? 4'hf : since_chg_reg + 4'h1;
    end
  end
  chk_reset_idle: assert property ($rose(rst_n) |-> chan_out && !irq_out)
    else $error("output or interrupt not idle at reset release");
  chk_irq_with_edge: assert property ($rose(irq_out) |-> (since_chg_reg <= 4'h4) or (##[0:2] $changed(chan_out)))
    else $error("interrupt raised without an output transition");
  chk_ctrl_bit14: assert property (s_axi_rvalid && rd_idx_reg == 4'h8 |-> !s_axi_rdata[14])
    else $error("control bit 14 read back as one");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && unm(s_axi_araddr[5:2]) |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  chk_wr_unmapped: assert property ($rose(s_axi_bvalid) && unm(wr_idx_reg) |-> s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cov_irq: cover property ($rose(irq_out));
  cov_pulse: cover property ($fell(chan_out));
endmodule
bind pmos_channel pmos_channel_props u_props (.clk(clk), .rst_n(rst_n), .chan_out(chan_out), .irq_out(irq_out),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- verif/pmos_field_model.sv
// field-side signal sources: measured input, external count clock, trigger
`timescale 1ns/10ps
`default_nettype none
module pmos_field_model (
  input wire logic clk,
  input wire logic [15:0] lo_len,
  input wire logic [15:0] hi_len,
  input wire logic clk_run,
  input wire logic trig_go,
  input wire logic [15:0] trig_len,
  output logic gate,
  output logic ext_clk,
  output logic trig
);
  int gcnt = 0;
  int ecnt = 0;
  int tcnt = 0;
  initial begin
    gate = 1'b0;
    ext_clk = 1'b0;
    trig = 1'b0;
  end
  // square wave with separate low and high lengths
  always @(posedge clk) begin
    gcnt <= gcnt + 1;
    if (gcnt + 1 >= (gate ? hi_len : lo_len)) begin
      gate <= ~gate;
      gcnt <= 0;
    end
  end
  // count clock of 8 cycles; stands still when stopped so no stray tick leaks in
  always @(posedge clk) begin
    if (!clk_run) begin
      ecnt <= 0;
      ext_clk <= 1'b0;
    end else if (ecnt == 3) begin
      ecnt <= 0;
      ext_clk <= ~ext_clk;
    end else ecnt <= ecnt + 1;
  end
  // one active-high trigger pulse per request
  always @(posedge clk) begin
    if (trig_go) tcnt <= trig_len;
    else if (tcnt > 0) tcnt <= tcnt - 1;
    trig <= trig_go || (tcnt > 1);
  end
endmodule
`default_nettype wire

//--- verif/period_measure_and_one_shot_tb.sv
// self-checking bench for the period meter / one-shot channel
`timescale 1ns/10ps
`default_nettype none
module period_measure_and_one_shot_tb;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, run, tgo;
  logic awready, wready, bvalid, arready, rvalid, chan_out, irq_out, gate, eclk, trig;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  logic [15:0] lo, hi, tlen;
  int miscompares, n_checks, w, b, pl, ph, e, t;
  logic [15:0] pcfg [4] = '{16'h9026, 16'h9466, 16'h9466, 16'h9016};
  int pdiv [4] = '{2, 8, 0, 6};
  pmos_channel DUT (.clk(clk), .rst_n(rst_n), .measured_gate_input(gate), .external_count_clock_input(eclk),
    .ext_trigger_input(trig), .chan_out(chan_out), .irq_out(irq_out), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pmos_field_model u_field (.clk(clk), .lo_len(lo), .hi_len(hi), .clk_run(run), .trig_go(tgo),
    .trig_len(tlen), .gate(gate), .ext_clk(eclk), .trig(trig));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] mn, input logic [31:0] mx, input logic [31:0] got);
    n_checks++;
    if ((^got === 1'bx) || got < mn || got > mx) begin
      miscompares++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, mn, mx, got);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [5:0] a, input logic [15:0] d);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitout(input logic v);
    int n;
    n = 0;
    while (chan_out !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    // a level that never shows up counts against the run
    if (chan_out !== v) begin
      miscompares++;
      $display("[FAIL] output level expected %0d seen %0d", v, chan_out);
    end
  endtask
  // length of the next active-low output pulse, -1 if none shows up
  task automatic meas(output int len);
    len = 0;
    waitout(1'b0);
    while (chan_out === 1'b0 && len < 5000) begin
      @(posedge clk);
      len++;
    end
    if (len == 0) len = -1;
  endtask
  task automatic fire(input int len);
    tlen <= len[15:0];
    tgo <= 1'b1;
    @(posedge clk);
    tgo <= 1'b0;
  endtask
  // hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_of_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, run, tgo} = 7'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    lo = 16'h0032;
    hi = 16'h0032;
    tlen = 16'h0000;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(82684));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    axw(6'h00, 16'h0001);
    axr(6'h00, rd, rr);
    chk("board setup", 1, 1, rd);
    axw(6'h20, 16'hffff);
    axr(6'h20, rd, rr);
    chk("control readback", 16'hbfff, 16'hbfff, rd);
    axw(6'h3c, 16'h0000);
    axr(6'h3c, rd, rr);
    chk("unmapped read resp", 2, 2, {30'h0, rr});
    $display("register test done");
    // internal tick, external clock, external clock absent, then slow carrier with low start
    for (int i = 0; i < 4; i++) begin
      pl = 40 + $urandom % 40;
      ph = 40 + $urandom % 40;
      lo <= pl[15:0];
      hi <= ph[15:0];
      run <= (i < 2);
      if (i == 3) axw(6'h00, 16'h0000);
      axw(6'h20, pcfg[i]);
      axw(6'h10, 16'h0001);
      meas(w);
      chk("done pulse", 87, 88, w);
      chk("irq raised", 1, 1, {31'h0, irq_out});
      axr(6'h2c, rd, rr);
      e = (pdiv[i] != 0) ? (pl + ph) / pdiv[i] : 0;
      t = (pdiv[i] != 0) ? 2 : 0;
      chk("period count", e - t, e + t, rd);
      if (i == 2) axw(6'h20, 16'h1466);
      else axw(6'h08, 16'h0001);
      // clearing through the enable bit lands one cycle later than the write-one clear
      @(posedge clk);
      chk("irq cleared", 0, 0, {31'h0, irq_out});
      if (i == 0) begin
        w = 0;
        repeat (400) begin
          @(posedge clk);
          if (chan_out !== 1'b1) w++;
        end
        chk("single measurement", 0, 0, w);
      end
      $display("period test %0d done", i);
    end
    axw(6'h00, 16'h0001);
    axw(6'h24, 16'h000a);
    b = 10 + $urandom % 20;
    axw(6'h28, b[15:0]);
    axw(6'h20, 16'h9207);
    for (int k = 0; k < 2; k++) begin
      fire(10);
      if (k == 0) begin
        meas(w);
        chk("pulse width", 2 * b, 2 * b + 4, w);
      end else begin
        waitout(1'b0);
        axw(6'h08, 16'h0001);
        chk("irq after clear", 0, 0, {31'h0, irq_out});
        waitout(1'b1);
      end
      repeat (2) @(posedge clk);
      chk("irq on edge", 1, 1, {31'h0, irq_out});
      axw(6'h08, 16'h0001);
    end
    $display("one-shot test done");
    axw(6'h20, 16'hb207);
    fire(40);
    w = 0;
    repeat (600) begin
      @(posedge clk);
      if (chan_out !== 1'b1) w++;
    end
    chk("short trigger rejected", 0, 0, w);
    fire(200);
    meas(w);
    chk("long trigger accepted", 2 * b, 2 * b + 4, w);
    $display("debounce test done");
    end_of_test();
  end
endmodule
`default_nettype wire
